// ===== logic/fhp_dma_if.sv
// signals between the phase logic and the dma request engine.
// assumes both ends run on pclk.
`timescale 1ns/1ns
interface fhp_dma_if;
   logic active;
   logic legacy;
   logic req;
   logic dack_low;
   logic dack_fall;
   logic dack_rise;
   logic drq;
   modport ctl (output active, output legacy, output req, output dack_low, output dack_fall,
      output dack_rise, input drq);
   modport eng (input active, input legacy, input req, input dack_low, input dack_fall,
      input dack_rise, output drq);
endinterface

// ===== logic/fhp_dma_req.sv
// dma request engine, fifo disabled: one request per byte.
// assumes dack edges arrive already synchronised to clk.
`timescale 1ns/1ns
module fhp_dma_req (
   input wire logic clk,
   input wire logic rst_n,
   fhp_dma_if.eng dif
);
   logic hold;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dif.drq <= 1'b0;
         hold <= 1'b0;
      end else if (!dif.active) begin
         dif.drq <= 1'b0;
         hold <= 1'b0;
      end else if (dif.dack_fall) begin
         dif.drq <= 1'b0;
         hold <= 1'b1;
      end else if (dif.dack_rise) begin
         // alternate mode behaves as a one-deep fifo at threshold 0fh
         hold <= dif.legacy;
         dif.drq <= !dif.legacy && dif.req;
      end else if (hold) begin
         hold <= 1'b0;
      end else if (dif.req && !dif.dack_low) begin
         dif.drq <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_drq_dack_drop: assert property (dif.dack_fall |=> !dif.drq)
      else $error("request still high after dack fell");
   chk_legacy_gap: assert property (dif.legacy && dif.dack_rise |=> !dif.drq [*2])
      else $error("legacy request not low between bytes");
endmodule

// ===== logic/fhp_pkg.sv
// constants, phase states and the opcode length table of the floppy host phase / dma port.
// assumes an apb master on pclk, and a drive/fifo core that is clocked on pclk.
// Operation
// - diagnostic input register is read only; software reset leaves it alone.
// - legacy drive mode: diagnostic bits 6..0 are left undriven on reads.
// - alternate drive mode: bit 0 reads 0 at 1M/500K, 1 at 300K/250K.
// - alternate drive mode: bits 2,1 return the last written rate select field.
// - bits 6..3 read ones in alternate mode, undriven in legacy mode.
// - bit 7 mirrors the disk changed input; undefined while powered down.
// - config control is write only, survives soft reset, hard reset gives 250K.
// - effective rate follows the later write of config control or rate select.
// - every command runs command, execution, result; otherwise idle or polling. Here an opcode with no result bytes skips the result phase.
// - first command byte opcode decides how many parameter bytes follow.
// - execution starts right after the last command byte is written.
// - command in progress set by first byte, held to last result byte.
// - non-dma execution raises an interrupt per byte; polling status also works.
// - dma: request while a byte is ready, drop at dack fall, irq at end.
// - during dma the address is ignored and dack selects the data register.
// - terminal count is honoured only while dack is low.
// - legacy mode: single byte dma, request low between bytes.
// - alternate mode: threshold 0fh, request returns when dack goes high.
// - request for master clears after each data byte, sets when ready again.
package fhp_pkg;
   // register indices; byte address is four times the index
   localparam logic [2:0] FHP_IDX_MODE = 3'h0;
   localparam logic [2:0] FHP_IDX_OUT = 3'h2;
   localparam logic [2:0] FHP_IDX_STA = 3'h4;
   localparam logic [2:0] FHP_IDX_DATA = 3'h5;
   localparam logic [2:0] FHP_IDX_CFG = 3'h7;
   localparam int FHP_ST_REQ = 7;
   localparam int FHP_ST_WAY = 6;
   localparam int FHP_ST_NDMA = 5;
   localparam int FHP_ST_PROG = 4;
   localparam int FHP_OUT_NRST = 2;
   localparam int FHP_OUT_DMA = 3;
   localparam int FHP_DSR_SRST = 7;
   localparam logic [1:0] FHP_RATE_RST = 2'h2;
   localparam logic [7:0] FHP_OUT_RST = 8'h00;
   localparam logic [3:0] FHP_DIAG_ONES = 4'hf;
   localparam logic [3:0] FHP_ALT_LEVEL = 4'hf;
   localparam logic [13:0] FHP_PIN_RST = 14'h3c00;
   typedef enum logic [4:0] {
      FHP_IDLE = 5'h01,
      FHP_POLL = 5'h02,
      FHP_CMD = 5'h04,
      FHP_EXEC = 5'h08,
      FHP_RES = 5'h10
   } fhp_phase_t;
   // {parameter bytes, result bytes} for opcode bits 4..0
   function automatic logic [7:0] fhp_cmd_len(input logic [4:0] op);
      case (op)
         5'h03: fhp_cmd_len = 8'h20;
         5'h04: fhp_cmd_len = 8'h11;
         5'h05: fhp_cmd_len = 8'h87;
         5'h06: fhp_cmd_len = 8'h87;
         5'h07: fhp_cmd_len = 8'h10;
         5'h08: fhp_cmd_len = 8'h02;
         5'h0f: fhp_cmd_len = 8'h20;
         default: fhp_cmd_len = 8'h01;
      endcase
   endfunction
endpackage

// ===== logic/fhp_port.sv
// host phase and dma port of the floppy controller: apb registers, phases, dma and irq.
// assumes the drive core on pclk; dma and drive pins arrive asynchronously.
`timescale 1ns/1ns
module fhp_port #(
   parameter int AW = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic disk_changed_input_n,
   input wire logic dack_n,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic tc,
   input wire logic aen,
   input wire logic [7:0] dma_wdata,
   output logic [7:0] dma_rdata,
   output logic dma_rdata_oe,
   output logic drq,
   output logic irq,
   output logic [7:0] diag_oe,
   input wire logic poll_active,
   input wire logic exec_req,
   input wire logic exec_to_host,
   input wire logic [7:0] exec_rdata,
   input wire logic exec_done,
   input wire logic [7:0] res_data,
   output logic [7:0] cmd_byte,
   output logic cmd_valid,
   output logic exec_start,
   output logic exec_ack,
   output logic [7:0] exec_wdata,
   output logic exec_tc,
   output logic res_take,
   output logic [1:0] rate_select_field,
   output logic soft_reset,
   output logic dma_mode,
   output logic alternate_drive_mode
);
   logic [13:0] pins_s;
   logic dchg_n_s, dack_n_s, ior_n_s, iow_n_s, tc_s, aen_s;
   logic [7:0] wdata_s;
   logic dack_n_d, iow_n_d;
   logic [7:0] digital_output_register;
   logic [7:0] mode_reg;
   fhp_pkg::fhp_phase_t phase, next_phase;
   logic [3:0] cmd_left, res_left;
   logic has_res, req_blank, res_irq;
   logic [2:0] idx;
   logic addr_ok, mapped, access, setup, wr_data, rd_data;
   logic wr_cfg, wr_dsr;
   logic request_for_master, transfer_direction_bit, nondma_exec, command_in_progress;
   logic [7:0] main_status_register, diag_input_status;
   logic [7:0] first_len;
   logic last_cmd;
   logic dack_fall, dack_rise;
   fhp_dma_if dif ();

   fhp_sync #(.W(14), .RST(fhp_pkg::FHP_PIN_RST)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({disk_changed_input_n, dack_n, ior_n, iow_n, tc, aen, dma_wdata}),
      .q(pins_s)
   );
   assign {dchg_n_s, dack_n_s, ior_n_s, iow_n_s, tc_s, aen_s, wdata_s} = pins_s;

   fhp_dma_req u_dma (
      .clk(pclk),
      .rst_n(presetn),
      .dif(dif)
   );

   // apb decode: zero wait states, answer in the access cycle
   assign idx = paddr[4:2];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr >> 5) == '0;
   assign mapped = addr_ok && (idx == fhp_pkg::FHP_IDX_MODE || idx == fhp_pkg::FHP_IDX_OUT
      || idx == fhp_pkg::FHP_IDX_STA || idx == fhp_pkg::FHP_IDX_DATA || idx == fhp_pkg::FHP_IDX_CFG);
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = access;
   assign pslverr = access && !mapped;
   // aen high means a dma cycle owns the bus; dack alone selects the data path
   assign wr_data = access && pwrite && mapped && idx == fhp_pkg::FHP_IDX_DATA && !aen_s;
   assign rd_data = access && !pwrite && mapped && idx == fhp_pkg::FHP_IDX_DATA && !aen_s;
   assign wr_cfg = access && pwrite && mapped && idx == fhp_pkg::FHP_IDX_CFG;
   assign wr_dsr = access && pwrite && mapped && idx == fhp_pkg::FHP_IDX_STA;

   // software reset: output register reset bit low, or self-clearing rate select bit
   assign soft_reset = !digital_output_register[fhp_pkg::FHP_OUT_NRST]
      || (wr_dsr && pwdata[fhp_pkg::FHP_DSR_SRST]);
   assign dma_mode = digital_output_register[fhp_pkg::FHP_OUT_DMA];
   assign alternate_drive_mode = mode_reg[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         digital_output_register <= fhp_pkg::FHP_OUT_RST;
         mode_reg <= 8'h00;
      end else if (access && pwrite && mapped) begin
         if (idx == fhp_pkg::FHP_IDX_OUT)
            digital_output_register <= pwdata[7:0];
         if (idx == fhp_pkg::FHP_IDX_MODE)
            mode_reg <= {7'h00, pwdata[0]};
      end
   end

   // one rate field, loaded by whichever register is written; no soft reset term
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rate_select_field <= fhp_pkg::FHP_RATE_RST;
      else if (wr_cfg || wr_dsr)
         rate_select_field <= pwdata[1:0]; // upper bits dropped
   end

   // phase sequencing
   assign first_len = fhp_pkg::fhp_cmd_len(pwdata[4:0]);
   assign last_cmd = wr_data && ((phase == fhp_pkg::FHP_CMD && cmd_left == 4'h1)
      || ((phase == fhp_pkg::FHP_IDLE || phase == fhp_pkg::FHP_POLL) && first_len[7:4] == 4'h0));

   always_comb begin
      next_phase = phase;
      case (phase)
         fhp_pkg::FHP_IDLE, fhp_pkg::FHP_POLL: begin
            if (wr_data)
               next_phase = last_cmd ? fhp_pkg::FHP_EXEC : fhp_pkg::FHP_CMD;
            else
               next_phase = poll_active ? fhp_pkg::FHP_POLL : fhp_pkg::FHP_IDLE;
         end
         fhp_pkg::FHP_CMD: begin
            if (last_cmd)
               next_phase = fhp_pkg::FHP_EXEC;
         end
         fhp_pkg::FHP_EXEC: begin
            if (exec_done)
               next_phase = has_res ? fhp_pkg::FHP_RES : fhp_pkg::FHP_IDLE;
         end
         fhp_pkg::FHP_RES: begin
            if (rd_data && res_left == 4'h1)
               next_phase = fhp_pkg::FHP_IDLE;
         end
         default: next_phase = fhp_pkg::FHP_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         phase <= fhp_pkg::FHP_IDLE;
      else if (soft_reset)
         phase <= fhp_pkg::FHP_IDLE;
      else
         phase <= next_phase;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_left <= 4'h0;
         res_left <= 4'h0;
         has_res <= 1'b0;
      end else if (soft_reset) begin
         cmd_left <= 4'h0;
         res_left <= 4'h0;
         has_res <= 1'b0;
      end else if (wr_data && (phase == fhp_pkg::FHP_IDLE || phase == fhp_pkg::FHP_POLL)) begin
         cmd_left <= first_len[7:4];
         res_left <= first_len[3:0];
         has_res <= first_len[3:0] != 4'h0;
      end else if (wr_data && phase == fhp_pkg::FHP_CMD) begin
         cmd_left <= cmd_left - 4'h1;
      end else if (rd_data && phase == fhp_pkg::FHP_RES) begin
         res_left <= res_left - 4'h1;
      end
   end

   // core strobes, all one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_byte <= 8'h00;
         cmd_valid <= 1'b0;
         exec_start <= 1'b0;
         res_take <= 1'b0;
      end else begin
         cmd_valid <= wr_data && !soft_reset && phase != fhp_pkg::FHP_EXEC && phase != fhp_pkg::FHP_RES;
         if (wr_data)
            cmd_byte <= pwdata[7:0];
         exec_start <= last_cmd && !soft_reset;
         res_take <= rd_data && phase == fhp_pkg::FHP_RES;
      end
   end

   // dma pin edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dack_n_d <= 1'b1;
         iow_n_d <= 1'b1;
      end else begin
         dack_n_d <= dack_n_s;
         iow_n_d <= iow_n_s;
      end
   end
   assign dack_fall = dack_n_d && !dack_n_s;
   assign dack_rise = !dack_n_d && dack_n_s;

   assign dif.active = dma_mode && phase == fhp_pkg::FHP_EXEC;
   assign dif.legacy = !alternate_drive_mode;
   assign dif.req = exec_req;
   assign dif.dack_low = !dack_n_s;
   assign dif.dack_fall = dack_fall;
   assign dif.dack_rise = dack_rise;
   assign drq = dif.drq;

   // a dack pulse counts as a byte even without a strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_ack <= 1'b0;
         exec_wdata <= 8'h00;
         exec_tc <= 1'b0;
         dma_rdata <= 8'h00;
         dma_rdata_oe <= 1'b0;
      end else begin
         exec_ack <= phase == fhp_pkg::FHP_EXEC && ((dif.active && dack_rise)
            || (!dma_mode && (wr_data || rd_data)));
         if (dif.active && !dack_n_s && !iow_n_d && iow_n_s)
            exec_wdata <= wdata_s;
         else if (!dma_mode && wr_data)
            exec_wdata <= pwdata[7:0];
         exec_tc <= tc_s && !dack_n_s && dif.active;
         if (dif.active && dack_fall)
            dma_rdata <= exec_rdata;
         dma_rdata_oe <= dif.active && !dack_n_s && !ior_n_s;
      end
   end

   // request for master drops for one cycle after each data byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         req_blank <= 1'b0;
      else
         req_blank <= wr_data || rd_data;
   end

   // result interrupt: set on entry to result phase, cleared by the first result read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         res_irq <= 1'b0;
      else if (soft_reset)
         res_irq <= 1'b0;
      else if (phase == fhp_pkg::FHP_EXEC && next_phase == fhp_pkg::FHP_RES)
         res_irq <= 1'b1;
      else if (rd_data && phase == fhp_pkg::FHP_RES)
         res_irq <= 1'b0;
   end

   assign nondma_exec = phase == fhp_pkg::FHP_EXEC && !dma_mode;
   assign request_for_master = !req_blank && (phase == fhp_pkg::FHP_IDLE || phase == fhp_pkg::FHP_POLL
      || phase == fhp_pkg::FHP_CMD || phase == fhp_pkg::FHP_RES || (nondma_exec && exec_req));
   assign transfer_direction_bit = phase == fhp_pkg::FHP_RES || (phase == fhp_pkg::FHP_EXEC && exec_to_host);
   // no result phase: the bit ends with the last command byte
   assign command_in_progress = phase == fhp_pkg::FHP_CMD || phase == fhp_pkg::FHP_RES
      || (phase == fhp_pkg::FHP_EXEC && has_res);
   assign main_status_register = {request_for_master, transfer_direction_bit, nondma_exec,
      command_in_progress, 4'h0};
   // per-byte interrupt in non-dma execution
   assign irq = (nondma_exec && exec_req && !req_blank) || res_irq;

   // diagnostic input: built from pins, rate and drive mode only, so soft reset cannot touch it
   assign diag_input_status = alternate_drive_mode
      ? {!dchg_n_s, fhp_pkg::FHP_DIAG_ONES, rate_select_field, ^rate_select_field}
      : {!dchg_n_s, 7'h00};

   // read data is registered in the setup cycle and stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         diag_oe <= 8'h00;
      end else if (setup && !pwrite) begin
         diag_oe <= 8'h00;
         prdata <= 32'h0000_0000;
         if (addr_ok) begin
            case (idx)
               fhp_pkg::FHP_IDX_MODE: prdata <= {24'h000000, mode_reg};
               fhp_pkg::FHP_IDX_OUT: prdata <= {24'h000000, digital_output_register};
               fhp_pkg::FHP_IDX_STA: prdata <= {24'h000000, main_status_register};
               fhp_pkg::FHP_IDX_DATA:
                  prdata <= {24'h000000, phase == fhp_pkg::FHP_RES ? res_data : exec_rdata};
               fhp_pkg::FHP_IDX_CFG: begin
                  prdata <= {24'h000000, diag_input_status};
                  diag_oe <= alternate_drive_mode ? 8'hff : 8'h80;
               end
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence cmd_last_write;
      last_cmd && !soft_reset;
   endsequence
   sequence diag_read_setup;
      setup && !pwrite && addr_ok && idx == fhp_pkg::FHP_IDX_CFG;
   endsequence

   chk_exec_follows_cmd: assert property (cmd_last_write |=> phase == fhp_pkg::FHP_EXEC)
      else $error("execution did not follow the last command byte");
   chk_req_after_byte: assert property ((wr_data || rd_data) |=> !request_for_master)
      else $error("request for master not cleared after data byte");
   chk_rate_last_write: assert property ((wr_cfg || wr_dsr) |=> rate_select_field == $past(pwdata[1:0]))
      else $error("rate field did not follow the last write");
   chk_diag_alt_bits: assert property (diag_read_setup ##0 alternate_drive_mode |=> prdata[6:0] ==
      {fhp_pkg::FHP_DIAG_ONES, $past(rate_select_field), ^$past(rate_select_field)})
      else $error("alternate diagnostic bits wrong");
   chk_diag_legacy_oe: assert property (diag_read_setup ##0 !alternate_drive_mode |=> diag_oe == 8'h80)
      else $error("legacy diagnostic low bits driven");
   chk_prog_first_byte: assert property (wr_data && phase == fhp_pkg::FHP_IDLE && !soft_reset
      && !last_cmd |=> command_in_progress)
      else $error("command in progress not set by first byte");
   chk_tc_needs_dack: assert property (exec_tc |-> $past(!dack_n_s))
      else $error("terminal count taken without dack");
   chk_result_irq: assert property (phase == fhp_pkg::FHP_EXEC && exec_done && has_res && !soft_reset
      |=> irq && phase == fhp_pkg::FHP_RES)
      else $error("no interrupt at start of result phase");
endmodule

// ===== logic/fhp_sync.sv
// two flip-flop synchroniser for a group of pin inputs.
// assumes pins change asynchronously to clk.
`timescale 1ns/1ns
module fhp_sync #(
   parameter int W = 14,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST;
         q <= RST;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ===== testbench/fhp_dma_host.sv
// isa dma controller model: answers drq with dack and read-strobe cycles.
// assumes pclk from the bench; drives the dma pins of the port.
`timescale 1ns/1ns
module fhp_dma_host #(
   parameter int BYTES = 3
) (
   input wire logic pclk,
   input wire logic drq,
   input wire logic [7:0] dma_rdata,
   input wire logic run,
   input wire logic gap_chk,
   output logic dack_n,
   output logic ior_n,
   output logic iow_n,
   output logic tc,
   output logic aen,
   output logic [7:0] dma_wdata,
   output logic [7:0] last_byte,
   output int done_cnt,
   output int errs
);
   initial begin
      {dack_n, ior_n, iow_n, tc, aen} = 5'h1c;
      dma_wdata = 8'h00;
      last_byte = 8'h00;
      done_cnt = 0;
      errs = 0;
   end
   // bus never shows a stale byte while nobody drives it
   always @(posedge pclk) dma_wdata <= ~dma_wdata;
   always @(posedge pclk) begin
      if (!run) begin
         done_cnt <= 0;
      end else if (drq === 1'b1 && done_cnt < BYTES) begin
         repeat (2) @(posedge pclk);
         aen <= 1'b1;
         dack_n <= 1'b0;
         ior_n <= 1'b0;
         tc <= (done_cnt == BYTES - 1);
         // slow answer: dack held long enough for the synced drop
         repeat (8) @(posedge pclk);
         if (drq !== 1'b0) errs <= errs + 1;
         last_byte <= dma_rdata;
         {dack_n, ior_n, tc, aen} <= 4'hc;
         done_cnt <= done_cnt + 1;
         if (gap_chk) begin
            repeat (2) begin
               @(posedge pclk);
               if (drq !== 1'b0) errs <= errs + 1;
            end
         end
      end
   end
endmodule

// ===== testbench/fhp_port_test.sv
// self-checking bench of the host phase and dma port: apb tasks, core stand-in, dma model.
// assumes the port, its package and the dma model compiled first.
`timescale 1ns/1ns
module fhp_port_test;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic disk_changed_input_n = 1;
   logic poll_active = 0;
   logic exec_req = 0;
   logic exec_to_host = 0;
   logic [7:0] exec_rdata = 8'h00;
   logic exec_done = 0;
   logic [7:0] res_data = 8'ha5;
   logic run = 0;
   logic gap_chk = 0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, dack_n, ior_n, iow_n, tc, aen, dma_rdata_oe, drq, irq, cmd_valid;
   logic exec_start, exec_ack, exec_tc, res_take, soft_reset, dma_mode, alternate_drive_mode;
   logic [7:0] dma_wdata, dma_rdata, diag_oe, cmd_byte, exec_wdata, last_byte;
   logic [1:0] rate_select_field, code;
   int fails = 0, tests_run = 0, n_start = 0, n_ack = 0, n_take = 0, tc_seen = 0, done_cnt, errs;
   fhp_port dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .disk_changed_input_n, .dack_n, .ior_n, .iow_n, .tc, .aen, .dma_wdata, .dma_rdata, .dma_rdata_oe,
      .drq, .irq, .diag_oe, .poll_active, .exec_req, .exec_to_host, .exec_rdata, .exec_done, .res_data,
      .cmd_byte, .cmd_valid, .exec_start, .exec_ack, .exec_wdata, .exec_tc, .res_take, .rate_select_field,
      .soft_reset, .dma_mode, .alternate_drive_mode);
   fhp_dma_host dma (.pclk, .drq, .dma_rdata, .run, .gap_chk, .dack_n, .ior_n, .iow_n, .tc, .aen,
      .dma_wdata, .last_byte, .done_cnt, .errs);
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      if (exec_start === 1'b1) n_start++;
      if (exec_ack === 1'b1) n_ack++;
      if (res_take === 1'b1) n_take++;
      if (exec_tc === 1'b1) tc_seen = 1;
   end
   task automatic end_of_test;
      $display("counts: %0d checks, %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic apb(input logic w, input logic [2:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {3'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
      if (n >= 20) begin
         fails++;
         end_of_test;
      end
   endtask
   task automatic wait_req(input logic to_host);
      int n;
      n = 0;
      do begin
         apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
         n++;
      end while (!(rdat[7] === 1'b1 && rdat[6] === to_host) && n < 30);
      if (rdat[7] !== 1'b1 || rdat[6] !== to_host) begin
         fails++;
         end_of_test;
      end
   endtask
   task automatic send(input logic [7:0] b);
      wait_req(1'b0);
      apb(1'b1, fhp_pkg::FHP_IDX_DATA, b);
   endtask
   task automatic pulse_done;
      @(posedge pclk);
      exec_done <= 1'b1;
      @(posedge pclk);
      exec_done <= 1'b0;
      repeat (2) @(negedge pclk);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      cmp_val(rate_select_field, 2'h2, "rate after reset");
      apb(1'b0, fhp_pkg::FHP_IDX_CFG, 8'h00);
      cmp_val(rdat, 32'h0, "legacy diag");
      cmp_val(diag_oe, 8'h80, "legacy drive enables");
      @(posedge pclk);
      disk_changed_input_n <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(1'b0, fhp_pkg::FHP_IDX_CFG, 8'h00);
      cmp_val(rdat, 32'h80, "disk changed bit");
      apb(1'b0, 3'h1, 8'h00);
      cmp_flag(rerr, 1'b1, "unmapped error");
      $display("test legacy_diag done");
      apb(1'b1, fhp_pkg::FHP_IDX_MODE, 8'h01);
      cmp_flag(alternate_drive_mode, 1'b1, "alternate mode set");
      for (int i = 0; i < 8; i++) begin
         code = i[1:0];
         // config control writes codes 0..3, then rate select writes them again; the later one must win
         apb(1'b1, i[2] ? fhp_pkg::FHP_IDX_STA : fhp_pkg::FHP_IDX_CFG, {6'h0, code});
         apb(1'b0, fhp_pkg::FHP_IDX_CFG, 8'h00);
         cmp_val(rdat, {24'h0, 1'b1, 4'hf, code, code[1] ^ code[0]}, "alternate diag");
         cmp_val(rate_select_field, code, "rate field");
      end
      cmp_val(diag_oe, 8'hff, "alternate drive enables");
      apb(1'b1, fhp_pkg::FHP_IDX_OUT, 8'h04);
      apb(1'b1, fhp_pkg::FHP_IDX_OUT, 8'h00);
      cmp_flag(soft_reset, 1'b1, "soft reset held");
      apb(1'b1, fhp_pkg::FHP_IDX_OUT, 8'h04);
      cmp_flag(soft_reset, 1'b0, "soft reset released");
      apb(1'b0, fhp_pkg::FHP_IDX_CFG, 8'h00);
      cmp_val(rdat, 32'hfe, "diag across soft reset");
      apb(1'b1, fhp_pkg::FHP_IDX_MODE, 8'h00);
      $display("test rates done");
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_val(rdat, 32'h80, "idle status");
      send(8'h07);
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_flag(rdat[4], 1'b1, "busy after opcode");
      send(8'h33);
      repeat (2) @(negedge pclk);
      cmp_val(n_start, 1, "exec after last byte");
      cmp_val(cmd_byte, 8'h33, "parameter byte");
      pulse_done;
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_val(rdat, 32'h80, "idle after no-result command");
      send(8'h08);
      repeat (2) @(negedge pclk);
      cmp_val(n_start, 2, "no-parameter opcode");
      pulse_done;
      cmp_flag(irq, 1'b1, "result irq");
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_val(rdat, 32'hd0, "result status");
      apb(1'b0, fhp_pkg::FHP_IDX_DATA, 8'h00);
      cmp_val(rdat, 32'ha5, "first result");
      cmp_flag(irq, 1'b0, "irq cleared by result read");
      @(posedge pclk);
      res_data <= 8'h5a;
      wait_req(1'b1);
      apb(1'b0, fhp_pkg::FHP_IDX_DATA, 8'h00);
      cmp_val(rdat, 32'h5a, "second result");
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_val(rdat, 32'h80, "idle after results");
      cmp_val(n_take, 2, "results taken");
      $display("test phases done");
      send(8'h04);
      send(8'h11);
      @(posedge pclk);
      exec_req <= 1'b1;
      repeat (2) @(negedge pclk);
      cmp_flag(irq, 1'b1, "byte irq");
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_val(rdat & 32'he0, 32'ha0, "non-dma status");
      apb(1'b1, fhp_pkg::FHP_IDX_DATA, 8'h3c);
      @(posedge pclk);
      exec_req <= 1'b0;
      repeat (2) @(negedge pclk);
      cmp_val(n_ack, 1, "exec byte taken");
      cmp_val(exec_wdata, 8'h3c, "exec byte value");
      apb(1'b0, fhp_pkg::FHP_IDX_STA, 8'h00);
      cmp_flag(rdat[7], 1'b0, "no request without byte");
      pulse_done;
      wait_req(1'b1);
      apb(1'b0, fhp_pkg::FHP_IDX_DATA, 8'h00);
      $display("test non_dma done");
      apb(1'b1, fhp_pkg::FHP_IDX_OUT, 8'h0c);
      cmp_flag(dma_mode, 1'b1, "dma mode selected");
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, fhp_pkg::FHP_IDX_MODE, m[7:0]);
         cmp_flag(alternate_drive_mode, m[0], "drive mode");
         send(8'h04);
         send(8'h22);
         @(posedge pclk);
         {exec_to_host, exec_req, run, gap_chk} <= {3'h7, m == 0};
         exec_rdata <= 8'h96;
         n_ack = 0;
         tc_seen = 0;
         for (int k = 0; k < 400 && done_cnt < 3; k++) @(posedge pclk);
         exec_req <= 1'b0;
         run <= 1'b0;
         cmp_val(done_cnt, 3, "dma bytes");
         cmp_val(last_byte, 8'h96, "dma data");
         cmp_val(errs, 0, "drq timing");
         cmp_val(tc_seen, 1, "terminal count");
         pulse_done;
         cmp_val(n_ack, 3, "dma acks");
         wait_req(1'b1);
         apb(1'b0, fhp_pkg::FHP_IDX_DATA, 8'h00);
         $display("test dma mode %0d done", m);
      end
      end_of_test;
   end
endmodule
